//--- rtl/opa_panel.sv
// Purpose: operator panel adapter control logic
// Assumes: panel buttons are raw pins; processor side is synchronous
// Notes:   direct control bus simplified to address, write and command strobes; reads need no strobe
`default_nettype none
module opa_panel
  import opa_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BLINK_HALF
) (
  input  wire logic        MCLK_I,       // processor clock
  input  wire logic        RSTN_I,       // power-on reset, low
  input  wire logic        SYS_RST_I,    // system reset pulse
  input  wire logic [7:0]  ADDR_I,       // device address
  input  wire logic        WR_CTL_I,     // write control word
  input  wire logic        WR_STS_I,     // write basic status word (clears)
  input  wire logic        WR_DISP_I,    // write display register
  input  wire logic        RST_ADP_I,    // reset-adapter command
  input  wire logic        SET_IFC_I,    // software sets interface check
  input  wire logic        LOAD_INSTR_I, // programmed load instruction
  input  wire logic        LOAD_END_I,   // logic ends load
  input  wire logic [15:0] WDATA_I,      // write data
  output logic      [15:0] DISP_RD_O,    // display read data
  output logic      [15:0] CTL_O,        // control word
  output logic      [15:0] STS_O,        // basic status word
  output logic             SEL_O,        // address match
  input  wire logic        KEY_FIT_I,    // key switch fitted
  input  wire logic [1:0]  KEY_POS_I,    // key switch position
  input  wire logic        MODE_MAN_I,   // load-mode switch manual
  input  wire logic        PWR_ON_SW_I,  // power switch on
  input  wire logic        KEY_STB_I,    // keypad digit pressed
  input  wire logic [3:0]  KEY_VAL_I,    // keypad digit
  input  wire logic        BTN_CLR_I,    // clear display
  input  wire logic        BTN_DATA_I,   // enter data
  input  wire logic        BTN_FUNC_I,   // enter function
  input  wire logic        BTN_LOAD_I,   // reset and load
  input  wire logic        BTN_PTEST_I,  // processor test
  input  wire logic        BTN_LTEST_I,  // lamp test
  input  wire logic        INPUT_OK_I,   // processor permits input
  input  wire logic [3:0]  CARD_PERR_I,  // card parity errors
  input  wire logic        ERR_I,        // any system check source
  input  wire logic        INTLK_OPEN_I, // cable interlock open
  input  wire logic        PANEL_ERR_I,  // program sets panel check
  input  wire logic        RUNNING_I,    // processor executing
  output logic             PWR_ON_REQ_O, // power-on sequence request
  output logic             PWR_OFF_O,    // power-off request
  output logic             LOAD_MAN_O,   // load parms from keypad
  output logic             SYS_RST_O,    // system reset from button
  output logic             LOAD_GO_O,    // start load sequence
  output logic      [15:0] DISP_O,       // display digits
  output logic             DISP_ON_O,    // display lit
  output logic             L_ATTN_O,     // attention lamp
  output logic             L_SYS_O,      // system check lamp
  output logic             L_IFC_O,      // interface check lamp
  output logic             L_PANEL_O,    // panel check lamp
  output logic             L_WAIT_O,     // wait lamp
  output logic             L_LOAD_O,     // load lamp
  output logic             L_TEST_O      // test mode lamp
);
  localparam int BW = $clog2(BLINK_CYC + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // every register of the block lives in this one struct

  typedef struct packed {
    logic [2:0]   s_data;
    logic [2:0]   s_func;
    logic [2:0]   s_load;
    logic [2:0]   s_key;
    logic [2:0]   s_clr;
    logic [2:0]   s_ptst;
    logic [15:0]  disp;
    logic [2:0]   cnt;
    logic [15:0]  ctl;
    logic [15:0]  sts;
    logic         sys;
    logic         ifc;
    logic         pnl;
    logic         wt;
    logic [BW-1:0] bc;
    logic         blink;
    opa_load_type ld;
  } opa_state_type;

  opa_state_type q, d;

  // ----------------------------------------------------------------
  // pin edge detect and key decode
  // ----------------------------------------------------------------
  // second and third stage disagree on a fresh press; first stage only feeds second
  function automatic logic rise(input logic [2:0] s);
    rise = (s[2:1] == 2'b01);
  endfunction

  logic sel, en, pwr_only, secure, btn_ok;
  assign sel      = (ADDR_I == PANEL_ADDR);
  assign en       = !KEY_FIT_I || KEY_POS_I == KEY_ENABLE;
  assign pwr_only = KEY_FIT_I && KEY_POS_I == KEY_POWER;
  assign secure   = KEY_FIT_I && KEY_POS_I == KEY_SECURE;
  assign btn_ok   = en;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    d.s_data = {q.s_data[1:0], BTN_DATA_I};
    d.s_func = {q.s_func[1:0], BTN_FUNC_I};
    d.s_load = {q.s_load[1:0], BTN_LOAD_I};
    d.s_key  = {q.s_key[1:0], KEY_STB_I};
    d.s_clr  = {q.s_clr[1:0], BTN_CLR_I};
    d.s_ptst = {q.s_ptst[1:0], BTN_PTEST_I};
    // keypad fills from the left, extras dropped
    if (btn_ok && INPUT_OK_I && rise(q.s_key) && q.cnt < 3'(DIGITS)) begin
      d.disp = q.disp | (16'(KEY_VAL_I) << (4 * (DIGITS - 1 - q.cnt)));
      d.cnt  = q.cnt + NIB_ONE[2:0];
    end
    if (btn_ok && rise(q.s_clr)) begin
      d.disp = ZERO16;
      d.cnt  = ZERO3;
    end
    if (btn_ok && rise(q.s_ptst))
      d.disp = {q.disp[15:4], (|CARD_PERR_I) ? NIB_ONE : NIB_PARITY_OK};
    if (sel && WR_DISP_I && !q.ctl[CTL_BLANK]) begin
      d.disp = WDATA_I;
      d.cnt  = ZERO3;
    end
    if (sel && WR_CTL_I)
      d.ctl = WDATA_I;
    if (sel && WR_STS_I)
      d.sts = q.sts & ~WDATA_I;
    if (LOAD_END_I)
      d.sts[STS_LOAD] = 1'b0;
    // sets win over status word write clears; the reset-adapter command still clears them
    if (btn_ok && rise(q.s_data)) begin
      d.sts[STS_DATA] = 1'b1;
      d.sts[STS_IRQ]  = 1'b1;
    end
    if (btn_ok && rise(q.s_func)) begin
      d.sts[STS_FUNC] = 1'b1;
      d.sts[STS_IRQ]  = 1'b1;
    end
    if (sel && LOAD_INSTR_I)
      d.sts[STS_LOAD] = 1'b1;
    d.sys = ERR_I;
    if (sel && SET_IFC_I && !q.sts[STS_LOAD])
      d.ifc = 1'b1;
    if (PANEL_ERR_I)
      d.pnl = 1'b1;
    d.wt = !RUNNING_I;
    // blink timer, half period per phase
    if (q.bc >= BW'(BLINK_CYC - 1)) begin
      d.bc    = '0;
      d.blink = !q.blink;
    end else begin
      d.bc = q.bc + 1'b1;
    end
    case (q.ld)
      LD_IDLE: if (btn_ok && rise(q.s_load)) d.ld = LD_RST;
      LD_RST:  d.ld = LD_LOAD;
      LD_LOAD: d.ld = LD_DONE;
      LD_DONE: d.ld = LD_IDLE;
      default: d.ld = LD_IDLE;
    endcase
    if (q.ld == LD_RST)
      d.sts[STS_LOAD] = 1'b1;
    if (SYS_RST_I || q.ld == LD_RST) begin
      d.ifc = 1'b0;
      d.pnl = 1'b0;
      d.wt  = 1'b0;
    end
    if (sel && RST_ADP_I) begin
      d.sts  = ZERO16;
      d.sys  = 1'b0;
      d.ifc  = 1'b0;
      d.pnl  = 1'b0;
    end
    if (INTLK_OPEN_I)
      d.pnl = 1'b1;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // power-on reset leaves the load bit set so the load lamp is lit
  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      q      <= '0;
      q.ld   <= LD_IDLE;
      q.sts  <= ZERO16 | (16'h0001 << STS_LOAD);
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs and lamps
  // ----------------------------------------------------------------
  // lamp test drives lamps only, never the hex display
  logic lt;
  assign lt           = btn_ok && BTN_LTEST_I;
  assign SEL_O        = sel;
  assign DISP_RD_O    = q.ctl[CTL_BLANK] ? ZERO16 : q.disp;
  assign CTL_O        = q.ctl;
  assign STS_O        = q.sts;
  assign PWR_ON_REQ_O = PWR_ON_SW_I && !secure;
  assign PWR_OFF_O    = !PWR_ON_SW_I;
  assign LOAD_MAN_O   = en && MODE_MAN_I;
  assign SYS_RST_O    = (q.ld == LD_RST);
  assign LOAD_GO_O    = (q.ld == LD_LOAD);
  assign DISP_O       = q.disp;
  assign DISP_ON_O    = !q.ctl[CTL_BLANK];
  assign L_ATTN_O     = q.ctl[CTL_ATTN] | lt;
  assign L_SYS_O      = q.sys | lt;
  assign L_IFC_O      = q.ifc | lt;
  assign L_PANEL_O    = q.pnl | lt;
  assign L_WAIT_O     = q.wt | lt;
  assign L_LOAD_O     = q.sts[STS_LOAD] | lt;
  assign L_TEST_O     = (q.ctl[CTL_TEST] & (!q.ctl[CTL_BLINK] | q.blink)) | lt;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_DATA_IRQ: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    btn_ok && rise(q.s_data) && !(sel && RST_ADP_I) |=> STS_O[STS_DATA] && STS_O[STS_IRQ])
    else $error("enter data did not set status");
  AST_FUNC_IRQ: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    btn_ok && rise(q.s_func) && !(sel && RST_ADP_I) |=> STS_O[STS_FUNC] && STS_O[STS_IRQ])
    else $error("enter function did not set status");
  AST_BLANK: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    q.ctl[CTL_BLANK] && sel && WR_DISP_I |=> $stable(DISP_O)) else $error("blank leak");
  AST_SECURE: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    secure |-> !PWR_ON_REQ_O && !LOAD_MAN_O) else $error("secure violated");
  AST_FOUR: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    q.cnt == 3'(DIGITS) && !rise(q.s_clr) && !WR_DISP_I && !rise(q.s_ptst) |=> $stable(DISP_O))
    else $error("fifth digit accepted");
  AST_INTLK: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    INTLK_OPEN_I |=> L_PANEL_O) else $error("panel check dropped");
  AST_IFC: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    !L_IFC_O && !lt && STS_O[STS_LOAD] && !PANEL_ERR_I |=> !L_IFC_O) else $error("ifc set in load");
  AST_ATTN: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    !lt |-> L_ATTN_O == CTL_O[CTL_ATTN]) else $error("attention lamp");
  sequence load_seq;
    SYS_RST_O ##1 LOAD_GO_O;
  endsequence
  AST_LOAD: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    q.ld == LD_IDLE && btn_ok && rise(q.s_load) |=> load_seq) else $error("load sequence");
  AST_CLR: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    btn_ok && rise(q.s_clr) && !rise(q.s_ptst) && !(sel && WR_DISP_I) |=> DISP_O == ZERO16)
    else $error("clear display failed");
  AST_WAIT: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    SYS_RST_I |=> !q.wt) else $error("wait lamp kept through system reset");
  AST_IRQ_HOLD: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    q.sts[STS_IRQ] && !(sel && (WR_STS_I || RST_ADP_I)) |=> q.sts[STS_IRQ])
    else $error("request bit dropped");
  AST_SYS: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    ERR_I && !(sel && RST_ADP_I) |=> L_SYS_O) else $error("system check missed");
  AST_LOADBIT: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    q.ld == LD_RST && !(sel && RST_ADP_I) |=> STS_O[STS_LOAD]) else $error("load bit not set");
  AST_LTEST: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    lt |-> L_ATTN_O && L_SYS_O && L_IFC_O && L_PANEL_O && L_WAIT_O && L_LOAD_O && L_TEST_O)
    else $error("lamp test incomplete");
  AST_TEST: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    q.ctl[CTL_TEST] && !q.ctl[CTL_BLINK] |-> L_TEST_O) else $error("test lamp dark");
  AST_DISP_WR: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    sel && WR_DISP_I && !q.ctl[CTL_BLANK] |=> DISP_O == $past(WDATA_I))
    else $error("display write lost");
endmodule
`default_nettype wire

//--- rtl/opa_pkg.sv
// Purpose: shared constants for the operator panel adapter
// Assumes: 100 MHz processor clock
// Notes:   bit positions of control and basic status words
`default_nettype none
package opa_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BLINK_HZ      = 2;
  localparam int unsigned BLINK_HALF    = CLK_HZ / (BLINK_HZ * 2);
  localparam logic [7:0]  PANEL_ADDR    = 8'h09;
  localparam int unsigned DIGITS        = 4;
  localparam int unsigned CTL_ATTN      = 0;
  localparam int unsigned CTL_TEST      = 1;
  localparam int unsigned CTL_BLINK     = 2;
  localparam int unsigned CTL_BLANK     = 4;
  localparam int unsigned STS_DATA      = 8;
  localparam int unsigned STS_FUNC      = 9;
  localparam int unsigned STS_LOAD      = 12;
  localparam int unsigned STS_IRQ       = 15;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [2:0]  ZERO3         = 3'h0;
  localparam logic [1:0]  KEY_SECURE    = 2'h0;
  localparam logic [1:0]  KEY_POWER     = 2'h1;
  localparam logic [1:0]  KEY_ENABLE    = 2'h2;
  localparam logic [3:0]  NIB_PARITY_OK = 4'h0;
  localparam logic [3:0]  NIB_ONE       = 4'h1;
  typedef enum logic [3:0] {
    LD_IDLE = 4'b0001,
    LD_RST  = 4'b0010,
    LD_LOAD = 4'b0100,
    LD_DONE = 4'b1000
  } opa_load_type;
endpackage
`default_nettype wire

//--- tb/opa_proc_model.sv
// Purpose: processor side model issuing panel commands
// Assumes: strobes change at the falling edge and last one cycle
// Notes:   kind 0 ctl, 1 status clear, 2 display, 3 reset adapter, 4 load
`default_nettype none
module opa_proc_model (
  input  wire logic        mclk_i,  // processor clock
  output logic      [7:0]  addr_o,  // device address
  output logic      [4:0]  stb_o,   // command strobes
  output logic      [15:0] wdata_o  // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 8'h00;
    stb_o = 5'h00;
    wdata_o = 16'h0000;
  end
  task automatic cmd(input int kind, input logic [7:0] addr, input logic [15:0] data);
    @(negedge mclk_i);
    addr_o = addr;
    wdata_o = data;
    stb_o = 5'h01 << kind;
    @(negedge mclk_i);
    // released bus shows the inverse, not the last value
    addr_o = ~addr;
    wdata_o = ~data;
    stb_o = 5'h00;
    @(negedge mclk_i);
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// Purpose: self-checking bench for the operator panel adapter
// Assumes: buttons held three cycles (lamp test five), effects settle within six more
// Notes:   driver queues expectations, a watcher compares them
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb;
  import opa_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic       [1:0] key_pos = KEY_ENABLE;
  logic       [3:0] key_val = 4'h0;
  logic       [3:0] perr = 4'h0;
  logic       [6:0] btn = 7'h00;
  logic             key_fit = 1'b1;
  logic             mode_man = 1'b0;
  logic             input_ok = 1'b1;
  logic             err = 1'b0;
  logic             intlk = 1'b0;
  logic             running = 1'b1;
  logic             sys_rst = 1'b0;
  wire logic  [7:0] addr;
  wire logic  [4:0] stb;
  wire logic [15:0] wdata, ctl, sts, disp;
  wire logic        ld_man, disp_on;
  wire logic  [6:0] lamps;
  wire logic [4:0][15:0] obs;
  int               n_fail = 0;
  int               checks_done = 0;
  int               seed = 60587;
  int               cyc = 0;
  logic      [15:0] exp_q[$];
  logic       [2:0] sel_q[$];
  logic      [15:0] v, e, r;
  assign obs = {{14'h0000, disp_on, ld_man}, {9'h000, lamps}, disp, ctl, sts};
  opa_proc_model P (.mclk_i(clk), .addr_o(addr), .stb_o(stb), .wdata_o(wdata));
  opa_panel #(.BLINK_CYC(4)) DUT (
    .MCLK_I(clk), .RSTN_I(rstn), .SYS_RST_I(sys_rst), .ADDR_I(addr), .WR_CTL_I(stb[0]),
    .WR_STS_I(stb[1]), .WR_DISP_I(stb[2]), .RST_ADP_I(stb[3]), .SET_IFC_I(1'b0),
    .LOAD_INSTR_I(stb[4]), .LOAD_END_I(1'b0), .WDATA_I(wdata), .DISP_RD_O(),
    .CTL_O(ctl), .STS_O(sts), .SEL_O(), .KEY_FIT_I(key_fit), .KEY_POS_I(key_pos),
    .MODE_MAN_I(mode_man), .PWR_ON_SW_I(1'b1), .KEY_STB_I(btn[0]), .KEY_VAL_I(key_val),
    .BTN_CLR_I(btn[1]), .BTN_DATA_I(btn[2]), .BTN_FUNC_I(btn[3]), .BTN_LOAD_I(btn[4]),
    .BTN_PTEST_I(btn[5]), .BTN_LTEST_I(btn[6]), .INPUT_OK_I(input_ok),
    .CARD_PERR_I(perr), .ERR_I(err), .INTLK_OPEN_I(intlk), .PANEL_ERR_I(1'b0),
    .RUNNING_I(running), .PWR_ON_REQ_O(), .PWR_OFF_O(), .LOAD_MAN_O(ld_man),
    .SYS_RST_O(), .LOAD_GO_O(), .DISP_O(disp), .DISP_ON_O(disp_on), .L_ATTN_O(lamps[0]),
    .L_SYS_O(lamps[1]), .L_IFC_O(lamps[2]), .L_PANEL_O(lamps[3]), .L_WAIT_O(lamps[4]),
    .L_LOAD_O(lamps[5]), .L_TEST_O(lamps[6]));
  always #5 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic expect_v(input logic [2:0] which, input logic [15:0] val);
    exp_q.push_back(val);
    sel_q.push_back(which);
  endtask
  task automatic press(input int b);
    @(negedge clk);
    btn[b] = 1'b1;
    repeat (3) @(negedge clk);
    btn[b] = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  always begin
    wait (exp_q.size() != 0);
    e = exp_q.pop_front();
    r = obs[sel_q.pop_front()];
    `CHK(r, e)
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test;
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    expect_v(0, 16'h1000);
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed)) & 16'hFFEB;
      P.cmd(0, PANEL_ADDR, v);
      expect_v(1, v);
      expect_v(3, {9'h000, v[1], 1'b1, 4'h0, v[0]});
    end
    P.cmd(0, 8'h0A, 16'hFFFF);
    expect_v(1, v);
    P.cmd(2, PANEL_ADDR, 16'h0000);
    v = 16'h0000;
    for (int i = 0; i < 5; i++) begin
      key_val = 4'($random(seed));
      if (i < 4)
        v[15 - 4 * i -: 4] = key_val;
      press(0);
    end
    expect_v(2, v);
    press(1);
    expect_v(2, 16'h0000);
    expect_v(0, 16'h1000);
    input_ok = 1'b0;
    key_val = 4'h7;
    press(0);
    expect_v(2, 16'h0000);
    input_ok = 1'b1;
    press(2);
    expect_v(0, 16'h9100);
    press(3);
    expect_v(0, 16'h9300);
    P.cmd(1, PANEL_ADDR, 16'h8300);
    expect_v(0, 16'h1000);
    P.cmd(1, PANEL_ADDR, 16'hFFFF);
    P.cmd(4, PANEL_ADDR, 16'h0000);
    expect_v(0, 16'h1000);
    mode_man = 1'b1;
    for (int k = 0; k < 2; k++) begin
      key_pos = k[1:0];
      press(2);
      press(4);
      expect_v(0, 16'h1000);
      expect_v(4, 16'h0002);
    end
    key_pos = KEY_ENABLE;
    @(negedge clk);
    expect_v(4, 16'h0003);
    mode_man = 1'b0;
    key_fit = 1'b0;
    key_pos = KEY_SECURE;
    press(2);
    expect_v(0, 16'h9100);
    key_fit = 1'b1;
    key_pos = KEY_ENABLE;
    P.cmd(1, PANEL_ADDR, 16'hFFFF);
    P.cmd(0, PANEL_ADDR, 16'h0010);
    P.cmd(2, PANEL_ADDR, 16'hABCD);
    expect_v(2, 16'h0000);
    expect_v(4, 16'h0000);
    P.cmd(0, PANEL_ADDR, 16'h0000);
    P.cmd(2, PANEL_ADDR, 16'hABCD);
    expect_v(4, 16'h0002);
    perr = 4'h4;
    press(5);
    expect_v(2, 16'hABC1);
    err = 1'b1;
    intlk = 1'b1;
    running = 1'b0;
    repeat (3) @(negedge clk);
    expect_v(3, 16'h001A);
    btn[6] = 1'b1;
    repeat (5) @(negedge clk);
    expect_v(3, 16'h007F);
    expect_v(2, 16'hABC1);
    btn[6] = 1'b0;
    err = 1'b0;
    P.cmd(3, PANEL_ADDR, 16'h0000);
    expect_v(3, 16'h0018);
    sys_rst = 1'b1;
    @(negedge clk);
    expect_v(3, 16'h0008);
    sys_rst = 1'b0;
    wait (exp_q.size() == 0);
    #1;
    finish_test;
  end
endmodule
`default_nettype wire
